// *** design/synth_ctl_pkg.sv ***
// constants, field layouts and types of the synthesizer program/control block
// assumes: a 10 MHz pclk and a host that drives the three-wire link
// Operation
// - data shifts in on rising link clock edge
// - last two bits shifted are the address
// - strobe rise loads word into addressed register
// - chip enable low means logical power-down
// - fast-settle pin low when active, else released
// - low two timeout bits override fast-settle pin
// - one selectable source drives the status output
// - programmed prescaler modulus pair, 32/33 or 16/17
package synth_ctl_pkg;

  localparam int WORD_W = 22;
  localparam int ADDR_W = 2;
  localparam int DATA_W = WORD_W - ADDR_W;
  localparam int PIN_N  = 6;

  localparam logic [1:0] ADDR_REF  = 2'h0;
  localparam logic [1:0] ADDR_FBK  = 2'h1;
  localparam logic [1:0] ADDR_FUNC = 2'h2;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_REF    = 8'h08;
  localparam logic [7:0] OFS_FBK    = 8'h0C;
  localparam logic [7:0] OFS_FUNC   = 8'h10;
  localparam logic [7:0] OFS_LOADS  = 8'h14;

  localparam int CTRL_SOFT_PD_BIT = 0;

  localparam logic [DATA_W-1:0] REF_RST  = 20'h00000;
  localparam logic [DATA_W-1:0] FBK_RST  = 20'h00000;
  localparam logic [DATA_W-1:0] FUNC_RST = 20'h00000;

  // pclk cycles per step of timeout_hi, the upper two bits of the timeout field
  localparam logic [15:0] TIMEOUT_UNIT_CYC = 16'h0020;

  typedef enum logic [1:0] {
    ST_DLD  = 2'h0,
    ST_ALD  = 2'h1,
    ST_RDIV = 2'h2,
    ST_NDIV = 2'h3
  } status_sel_e;

  typedef enum logic [1:0] {
    FS_NORMAL = 2'h0,
    FS_HIZ    = 2'h1,
    FS_LOW    = 2'h2,
    FS_HIGH   = 2'h3
  } fs_override_e;

  typedef enum logic [2:0] {
    FL_OFF   = 3'h1,
    FL_TIMED = 3'h2,
    FL_HOLD  = 3'h4
  } fl_state_e;

  // function register; timeout field is {timeout_hi, fs_override}
  typedef struct packed {
    logic [9:0]   spare;
    logic [1:0]   timeout_hi;
    fs_override_e fs_override;
    logic         power_down;
    logic         presc_sel;
    status_sel_e  status_sel;
    logic         fs_timed;
    logic         fs_en;
  } func_s;

  // pins from the analog side and the board, synchronised as a group
  typedef struct packed {
    logic chip_enable;
    logic load_strobe;
    logic lock_digital;
    logic lock_analog;
    logic ref_div;
    logic fb_div;
  } pins_s;

endpackage

// *** design/synth_serial_ctl.sv ***
// program/control logic of the synthesizer: serial link, control registers,
// fast-settle and status pins, APB window onto the programmed state
// assumes: host keeps sclk idle from the last bit until load_strobe is seen
`timescale 1ns/1ps
`default_nettype none
module synth_serial_ctl
  import synth_ctl_pkg::*;
#(
  parameter logic [15:0] TIMEOUT_UNIT = TIMEOUT_UNIT_CYC
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic        load_strobe,
  input  wire logic        chip_enable,
  input  wire logic        lock_digital,
  input  wire logic        lock_analog,
  input  wire logic        ref_div_in,
  input  wire logic        fb_div_in,
  output logic             fast_settle_output,
  output logic             fast_settle_output_oe_n,
  output logic             muxed_status_output,
  output logic             muxed_status_output_oe_n,
  output logic             power_down,
  output logic             presc_small_mod
);

  logic [WORD_W-1:0] link_word;
  logic [WORD_W-1:0] word_meta_reg;
  logic [WORD_W-1:0] word_sync_reg;
  pins_s             pins_in;
  pins_s             pins_meta_reg;
  pins_s             pins_sync_reg;
  logic              le_prev_reg;
  logic [DATA_W-1:0] ref_reg;
  logic [DATA_W-1:0] fbk_reg;
  func_s             func_reg;
  logic              soft_pd_reg;
  logic [15:0]       loads_reg;
  logic [15:0]       timer_reg;
  logic [15:0]       timer_next;
  fl_state_e         fl_reg;
  fl_state_e         fl_next;
  logic              fs_out_reg;
  logic              fs_oe_n_reg;
  logic              st_out_reg;
  logic              st_oe_n_reg;
  logic              pd_reg;
  logic              presc_reg;
  logic [31:0]       prdata_reg;

  word_shifter #(
    .W       (WORD_W)
  ) u_shift (
    .sclk    (sclk),
    .presetn (presetn),
    .sdata   (sdata),
    .word    (link_word)
  );

  // word is static while the strobe rises, so a plain two-stage bus
  // synchroniser is safe; a word still shifting when the strobe arrives
  // may load mixed bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_meta_reg <= '0;
      word_sync_reg <= '0;
      pins_meta_reg <= '0;
      pins_sync_reg <= '0;
      le_prev_reg   <= 1'b0;
    end
    else
    begin
      word_meta_reg <= link_word;
      word_sync_reg <= word_meta_reg;
      pins_meta_reg <= pins_in;
      pins_sync_reg <= pins_meta_reg;
      le_prev_reg   <= pins_sync_reg.load_strobe;
    end
  end

  assign pins_in = '{chip_enable:  chip_enable,
                     load_strobe:  load_strobe,
                     lock_digital: lock_digital,
                     lock_analog:  lock_analog,
                     ref_div:      ref_div_in,
                     fb_div:       fb_div_in};

  wire logic              le_rise   = pins_sync_reg.load_strobe & ~le_prev_reg;
  wire logic [1:0]        word_addr = word_sync_reg[ADDR_W-1:0];
  wire logic [DATA_W-1:0] word_data = word_sync_reg[WORD_W-1:ADDR_W];
  wire logic              ld_ref    = le_rise && word_addr == ADDR_REF;
  wire logic              ld_fbk    = le_rise && word_addr == ADDR_FBK;
  wire logic              ld_func   = le_rise && word_addr == ADDR_FUNC;
  wire func_s             func_new  = func_s'(word_data);

  // control registers change on a strobe rise and never otherwise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_reg  <= REF_RST;
      fbk_reg  <= FBK_RST;
      func_reg <= func_s'(FUNC_RST);
    end
    else
    begin
      if (ld_ref)
        ref_reg <= word_data;
      if (ld_fbk)
        fbk_reg <= word_data;
      if (ld_func)
        func_reg <= func_new;
    end
  end

  // address 3 selects nothing; such words are dropped and not counted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      loads_reg <= 16'h0000;
    else if (ld_ref | ld_fbk | ld_func)
      loads_reg <= loads_reg + 16'h0001;
  end

  wire logic pd_now = ~pins_sync_reg.chip_enable | func_reg.power_down | soft_pd_reg;

  // fast-settle: held while enabled, or timed from each feedback load except one landing on the last count
  wire logic [15:0] timeout_cyc =
    16'({14'h0000, func_reg.timeout_hi} + 16'h0001) * TIMEOUT_UNIT;

  always_comb
  begin
    fl_next    = fl_reg;
    timer_next = timer_reg;
    unique case (fl_reg)
      FL_OFF:
      begin
        if (!pd_now && func_reg.fs_en && !func_reg.fs_timed)
          fl_next = FL_HOLD;
        else if (!pd_now && func_reg.fs_en && ld_fbk)
        begin
          fl_next    = FL_TIMED;
          timer_next = timeout_cyc;
        end
      end
      FL_TIMED:
      begin
        if (pd_now || !func_reg.fs_en || timer_reg <= 16'h0001)
        begin
          fl_next    = FL_OFF;
          timer_next = 16'h0000;
        end
        else if (ld_fbk)
          timer_next = timeout_cyc;
        else
          timer_next = timer_reg - 16'h0001;
      end
      FL_HOLD:
      begin
        if (pd_now || !func_reg.fs_en || func_reg.fs_timed)
          fl_next = FL_OFF;
      end
      default:
      begin
        fl_next    = FL_OFF;
        timer_next = 16'h0000;
      end
    endcase
  end

  wire logic fs_active = fl_reg != FL_OFF;

  // override codes come first; normal mode only pulls low
  wire logic fs_oe_n_next =
    func_reg.fs_override == FS_HIZ    ? 1'b1 :
    func_reg.fs_override == FS_NORMAL ? ~fs_active :
                                        1'b0;
  wire logic fs_out_next = func_reg.fs_override == FS_HIGH;

  // analog lock is open drain: pulled low while unlocked, else released
  wire logic st_src =
    func_reg.status_sel == ST_DLD  ? pins_sync_reg.lock_digital :
    func_reg.status_sel == ST_RDIV ? pins_sync_reg.ref_div :
    func_reg.status_sel == ST_NDIV ? pins_sync_reg.fb_div :
                                     1'b0;
  wire logic st_oe_n_next =
    func_reg.status_sel == ST_ALD && pins_sync_reg.lock_analog;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fl_reg      <= FL_OFF;
      timer_reg   <= 16'h0000;
      fs_out_reg  <= 1'b0;
      fs_oe_n_reg <= 1'b1;
      st_out_reg  <= 1'b0;
      st_oe_n_reg <= 1'b0;
      pd_reg      <= 1'b1;
      presc_reg   <= 1'b0;
    end
    else
    begin
      fl_reg      <= fl_next;
      timer_reg   <= timer_next;
      fs_out_reg  <= fs_out_next;
      fs_oe_n_reg <= fs_oe_n_next;
      st_out_reg  <= st_src;
      st_oe_n_reg <= st_oe_n_next;
      pd_reg      <= pd_now;
      presc_reg   <= func_reg.presc_sel;
    end
  end

  assign fast_settle_output       = fs_out_reg;
  assign fast_settle_output_oe_n  = fs_oe_n_reg;
  assign muxed_status_output      = st_out_reg;
  assign muxed_status_output_oe_n = st_oe_n_reg;
  assign power_down               = pd_reg;
  assign presc_small_mod          = presc_reg;

  // APB slave: no wait states, read data captured in the setup cycle
  wire logic apb_setup = psel & ~penable;
  wire logic apb_wr    = psel & penable & pwrite;
  wire logic addr_hit  = paddr == OFS_CTRL || paddr == OFS_STATUS ||
                         paddr == OFS_REF || paddr == OFS_FBK ||
                         paddr == OFS_FUNC || paddr == OFS_LOADS;

  wire logic [31:0] status_word = {26'h0000000, func_reg.fs_override,
                                   pins_sync_reg.load_strobe, fs_active,
                                   pd_reg, pins_sync_reg.chip_enable};

  wire logic [31:0] rd_mux =
    paddr == OFS_CTRL   ? {31'h00000000, soft_pd_reg} :
    paddr == OFS_STATUS ? status_word :
    paddr == OFS_REF    ? {12'h000, ref_reg} :
    paddr == OFS_FBK    ? {12'h000, fbk_reg} :
    paddr == OFS_FUNC   ? {12'h000, func_reg} :
    paddr == OFS_LOADS  ? {16'h0000, loads_reg} :
                          32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= 32'h00000000;
      soft_pd_reg <= 1'b0;
    end
    else
    begin
      if (apb_setup)
        prdata_reg <= rd_mux;
      if (apb_wr && paddr == OFS_CTRL)
        soft_pd_reg <= pwdata[CTRL_SOFT_PD_BIT];
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_ld_ref;
    le_rise && word_addr == ADDR_REF;
  endsequence

  sequence s_ld_func;
    le_rise && word_addr == ADDR_FUNC;
  endsequence

  property p_load_ref;
    s_ld_ref |=> ref_reg == $past(word_data) && $stable(fbk_reg);
  endproperty
  a_load_ref: assert property (p_load_ref) else $error("ref load wrong");

  property p_addr_func;
    s_ld_func |=> func_reg == $past(word_data) && $stable(ref_reg);
  endproperty
  a_addr_func: assert property (p_addr_func) else $error("address decode wrong");

  property p_no_strobe;
    !le_rise |=> $stable(ref_reg) && $stable(fbk_reg) && $stable(func_reg);
  endproperty
  a_no_strobe: assert property (p_no_strobe) else $error("register changed");

  property p_ce_low;
    !pins_sync_reg.chip_enable |=> power_down;
  endproperty
  a_ce_low: assert property (p_ce_low) else $error("no power-down");

  property p_fs_drive;
    fs_active && func_reg.fs_override == FS_NORMAL
      |=> !fast_settle_output_oe_n && !fast_settle_output;
  endproperty
  a_fs_drive: assert property (p_fs_drive) else $error("fast-settle not low");

  property p_fs_release;
    !fs_active && func_reg.fs_override == FS_NORMAL |=> fast_settle_output_oe_n;
  endproperty
  a_fs_release: assert property (p_fs_release) else $error("pin not released");

  property p_fs_high;
    (func_reg.fs_override == FS_HIGH) [*2] |-> !fast_settle_output_oe_n && fast_settle_output;
  endproperty
  a_fs_high: assert property (p_fs_high) else $error("force high failed");

  // timed mode must end when its count runs out, else the pin stays low forever
  property p_fs_timeout;
    fl_reg == FL_TIMED && timer_reg <= 16'h0001 |=> fl_reg != FL_TIMED;
  endproperty
  a_fs_timeout: assert property (p_fs_timeout) else $error("timed fast-settle stuck");

  property p_st_rdiv;
    func_reg.status_sel == ST_RDIV
      |=> muxed_status_output == $past(pins_sync_reg.ref_div) && !muxed_status_output_oe_n;
  endproperty
  a_st_rdiv: assert property (p_st_rdiv) else $error("status mux wrong");

  property p_presc;
    ld_func ##1 1'b1 |=> presc_small_mod == $past(func_reg.presc_sel);
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler select wrong");

endmodule
`default_nettype wire

// *** design/word_shifter.sv ***
// serial input shift register on the link clock
// assumes: sdata changes away from the rising sclk edge
`timescale 1ns/1ps
`default_nettype none
module word_shifter
  import synth_ctl_pkg::*;
#(
  parameter int W = WORD_W
)
(
  input  wire logic         sclk,
  input  wire logic         presetn,
  input  wire logic         sdata,
  output logic [W-1:0]      word
);

  always_ff @(posedge sclk or negedge presetn)
  begin
    if (!presetn)
      word <= '0;
    else
      word <= {word[W-2:0], sdata};
  end

  property p_shift;
    @(posedge sclk) disable iff (!presetn)
      word[W-1:1] == $past(word[W-2:0]) && word[0] == $past(sdata);
  endproperty
  a_shift: assert property (p_shift) else $error("shift register did not shift");

endmodule
`default_nettype wire

// *** tb/link_host.sv ***
// host-side model of the three-wire programming link
// assumes: bench calls send_word only after reset has been released
`timescale 1ns/1ps
`default_nettype none
module link_host
  import synth_ctl_pkg::*;
(
  output logic sclk,
  output logic sdata,
  output logic load_strobe
);
  initial
  begin
    sclk = 1'b0;
    sdata = 1'b0;
    load_strobe = 1'b0;
  end

  // sclk runs only inside a frame; strobe kept well clear of the last edge
  task automatic send_word(input logic [WORD_W-1:0] w, input logic strobe);
    for (int i = WORD_W - 1; i >= 0; i--)
    begin
      sdata = w[i];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    // inverted last bit on the line: no stale value left for a lucky match
    sdata = ~w[0];
    #100;
    if (strobe)
    begin
      load_strobe = 1'b1;
      #800 load_strobe = 1'b0;
    end
    #500;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_synth_serial_program_control.sv ***
// self-checking bench of the synthesizer program/control block
// assumes: link_host model drives the serial link, bench drives APB and pins
`timescale 1ns/1ps
`default_nettype none
module tb_synth_serial_program_control;
  import synth_ctl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        sclk, sdata, load_strobe, chip_enable;
  logic [3:0]  src;
  logic        fs_out, fs_oe_n, ms_out, ms_oe_n, pd, presc;
  int          num_errors, n_checks;
  func_s       f;
  logic [31:0] r;
  logic        e;

  synth_serial_ctl #(.TIMEOUT_UNIT(16'h0004)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclk(sclk), .sdata(sdata),
    .load_strobe(load_strobe), .chip_enable(chip_enable),
    .lock_digital(src[0]), .lock_analog(src[1]), .ref_div_in(src[2]),
    .fb_div_in(src[3]), .fast_settle_output(fs_out),
    .fast_settle_output_oe_n(fs_oe_n), .muxed_status_output(ms_out),
    .muxed_status_output_oe_n(ms_oe_n), .power_down(pd),
    .presc_small_mod(presc));

  link_host host_u (.sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one APB transfer; waits for pready but never assumes its timing
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
      chk(32'h0000DEAD, 32'h0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  task automatic ld(input logic [DATA_W-1:0] d, input logic [1:0] a);
    host_u.send_word({d, a}, 1'b1);
  endtask

  task automatic fn(input func_s v);
    ld(v, ADDR_FUNC);
    repeat (3) @(posedge pclk);
  endtask

  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask

  initial
  begin
    #400000;
    num_errors++;
    final_report();
  end

  initial
  begin
    num_errors = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    chip_enable = 1'b1;
    src = 4'h0;
    f = '0;
    repeat (10) @(posedge pclk);
    chk(pd, 1'b1);
    chk(fs_oe_n, 1'b1);
    presetn <= 1'b1;
    settle();
    chk(pd, 1'b0);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h00000001);
    for (int i = 0; i < 4; i++)
      rd(OFS_REF + 8'(4 * i), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({r[30:0], e}, 32'h1);
    $display("test reset done");

    ld(20'hABCDE, ADDR_REF);
    ld(20'h80001, ADDR_FBK);
    rd(OFS_REF, 32'h000ABCDE);
    rd(OFS_FBK, 32'h00080001);
    rd(OFS_LOADS, 32'h2);
    host_u.send_word({20'h55555, ADDR_REF}, 1'b0);
    rd(OFS_REF, 32'h000ABCDE);
    ld(20'hFFFFF, 2'h3);
    rd(OFS_LOADS, 32'h2);
    rd(OFS_FBK, 32'h00080001);
    rd(OFS_FUNC, 32'h0);
    apb(1'b1, OFS_REF, 32'h0);
    rd(OFS_REF, 32'h000ABCDE);
    $display("test load done");

    f.presc_sel = 1'b1;
    fn(f);
    chk(presc, 1'b1);
    rd(OFS_FUNC, {12'h0, f});
    f.presc_sel = 1'b0;
    fn(f);
    chk(presc, 1'b0);
    $display("test prescaler done");

    // selected source opposes all others, so a wrong pick shows
    for (int s = 0; s < 4; s++)
    begin
      f.status_sel = status_sel_e'(s);
      fn(f);
      for (int v = 0; v < 2; v++)
      begin
        @(posedge pclk);
        src <= v[0] ? 4'(4'b0001 << s) : ~4'(4'b0001 << s);
        settle();
        chk(ms_oe_n, (s == 1) && v[0]);
        if (!((s == 1) && v[0]))
          chk(ms_out, v[0]);
      end
    end
    $display("test status mux done");

    f = '0;
    f.fs_en = 1'b1;
    fn(f);
    chk({fs_out, fs_oe_n}, 2'b00);
    rd(OFS_STATUS, 32'h00000005);
    f.fs_en = 1'b0;
    fn(f);
    chk(fs_oe_n, 1'b1);
    // override wins even while fast-settle is held active
    for (int o = 1; o < 4; o++)
    begin
      f.fs_en = 1'b1;
      f.fs_override = fs_override_e'(o);
      fn(f);
      chk(fs_oe_n, o == 1);
      if (o != 1)
        chk(fs_out, o == 3);
    end
    // timed mode: active for 16 pclk from a feedback load, then released
    f = '0;
    f.fs_en = 1'b1;
    f.fs_timed = 1'b1;
    f.timeout_hi = 2'h3;
    fn(f);
    chk(fs_oe_n, 1'b1);
    ld(20'h00001, ADDR_FBK);
    chk({fs_out, fs_oe_n}, 2'b00);
    repeat (20) @(posedge pclk);
    chk(fs_oe_n, 1'b1);
    f = '0;
    fn(f);
    $display("test fast-settle done");

    @(posedge pclk);
    chip_enable <= 1'b0;
    settle();
    chk(pd, 1'b1);
    rd(OFS_STATUS, 32'h00000002);
    chip_enable <= 1'b1;
    settle();
    chk(pd, 1'b0);
    f.power_down = 1'b1;
    fn(f);
    chk(pd, 1'b1);
    f = '0;
    fn(f);
    chk(pd, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h1);
    settle();
    chk(pd, 1'b1);
    rd(OFS_CTRL, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h0);
    settle();
    chk(pd, 1'b0);
    $display("test power-down done");
    final_report();
  end
endmodule
`default_nettype wire
